/* File: rtl/sleep_reset_ctl.sv */
// Sleep mode clock gating, reset pin handling and port pin control.
// Assumes the CPU raises sleep requests and wake events on the system clock.
`timescale 1ns/100ps
module sleep_reset_ctl
  import sleep_ctl_pkg::*;
#(
  parameter int unsigned MIN_RST_CYC = RST_MIN_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Configuration
  input wire logic RESET_PIN_DISABLE_FUSE,
  input wire logic ASYNC_TIMER_CLOCK_SELECT,
  input wire logic RC_OSC_IS_SYSCLK,
  // Sleep control
  input wire logic SLEEP_REQ,
  input wire logic [2:0] SLEEP_MODE,
  input wire logic WAKE_IRQ,
  // Port data from the core
  input wire logic [7:0] PORT_B_OUT,
  input wire logic [7:0] PORT_B_DIR,
  input wire logic [7:0] PORT_B_PULLUP,
  input wire logic [6:0] PORT_C_OUT,
  input wire logic [6:0] PORT_C_DIR,
  input wire logic [6:0] PORT_C_PULLUP,
  input wire logic [7:0] PORT_D_OUT,
  input wire logic [7:0] PORT_D_DIR,
  input wire logic [7:0] PORT_D_PULLUP,
  // Port pins
  input wire logic [7:0] PB_I,
  output logic [7:0] PB_O,
  output logic [7:0] PB_OE_N,
  output logic [7:0] PB_PU,
  input wire logic [6:0] PC_I,
  output logic [6:0] PC_O,
  output logic [6:0] PC_OE_N,
  output logic [6:0] PC_PU,
  input wire logic [7:0] PD_I,
  output logic [7:0] PD_O,
  output logic [7:0] PD_OE_N,
  output logic [7:0] PD_PU,
  // Pin values seen by the core
  output logic [7:0] PORT_B_IN,
  output logic [6:0] PORT_C_IN,
  output logic [7:0] PORT_D_IN,
  // Async timer oscillator inputs
  output logic TIMER_OSC_INPUT_ONE,
  output logic TIMER_OSC_INPUT_TWO,
  output logic TIMER_OSC_ROUTED,
  // Clock enables and status
  output logic [7:0] CLK_GATES,
  output logic CHIP_RESET,
  output logic SLEEPING
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (PORT_B_W != 8 || PORT_C_W != 7 || PORT_D_W != 8) begin : g_bad_width
    $error("Port widths do not match the pin ports");
  end

  if (MIN_RST_CYC < 1) begin : g_bad_min
    $error("MIN_RST_CYC must be at least one");
  end

  if (SHARED_RST_BIT >= PORT_C_W) begin : g_bad_rst_bit
    $error("Shared reset pin lies outside port C");
  end

  if (XTAL_IN_BIT >= PORT_B_W || XTAL_OUT_BIT >= PORT_B_W) begin : g_bad_xtal
    $error("Crystal pins lie outside port B");
  end

  if (GT_W != 8) begin : g_bad_gates
    $error("Clock gate vector must be eight bits wide");
  end

  // ---------------------------------------------------------------
  // Reset pin
  // ---------------------------------------------------------------
  logic pin_rst;
  logic reset_pin_active;

  assign reset_pin_active = ~RESET_PIN_DISABLE_FUSE;

  reset_pin_filter #(
    .MIN_CYC(MIN_RST_CYC)
  ) u_rst_filter (
    .clk(CLK),
    .srst(SYS_RST),
    .enable(reset_pin_active),
    .pin_level(PC_I[SHARED_RST_BIT]),
    .pin_rst(pin_rst)
  );

  logic any_rst;
  assign any_rst = SYS_RST | pin_rst;
  assign CHIP_RESET = any_rst;

  // ---------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------
  pm_state_t state_q, state_d;
  sleep_mode_t mode_q, mode_d;

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    case (state_q)
      ST_RESET: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (SLEEP_REQ) begin
          case (SLEEP_MODE)
            SM_IDLE, SM_ADC_NR, SM_PWR_DOWN, SM_PWR_SAVE, SM_STANDBY: begin
              mode_d = sleep_mode_t'(SLEEP_MODE);
              state_d = ST_SLEEP;
            end
            default: begin
              state_d = ST_RUN;
            end
          endcase
        end
      end
      ST_SLEEP: begin
        if (WAKE_IRQ) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (any_rst) begin
      state_q <= ST_RESET;
      mode_q <= SM_IDLE;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
    end
  end

  assign SLEEPING = (state_q == ST_SLEEP);

  // ---------------------------------------------------------------
  // Clock gates per mode
  // ---------------------------------------------------------------
  logic [7:0] gates;

  always_comb begin
    gates = GATES_ALL;
    if (state_q == ST_SLEEP) begin
      gates = '0;
      case (mode_q)
        SM_IDLE: begin
          gates[GT_SRAM] = 1'b1;
          gates[GT_TIMER] = 1'b1;
          gates[GT_SPI] = 1'b1;
          gates[GT_IRQ] = 1'b1;
          gates[GT_ADC] = 1'b1;
          gates[GT_ASYNC] = 1'b1;
          gates[GT_OSC] = 1'b1;
        end
        SM_ADC_NR: begin
          gates[GT_ADC] = 1'b1;
          gates[GT_ASYNC] = 1'b1;
          gates[GT_IRQ] = 1'b1;
          gates[GT_OSC] = 1'b1;
        end
        SM_PWR_DOWN: begin
          gates[GT_IRQ] = 1'b1;
        end
        SM_PWR_SAVE: begin
          gates[GT_ASYNC] = 1'b1;
          gates[GT_IRQ] = 1'b1;
        end
        SM_STANDBY: begin
          gates[GT_OSC] = 1'b1;
          gates[GT_IRQ] = 1'b1;
        end
        default: begin
          gates = GATES_ALL;
        end
      endcase
    end
  end

  // Wake logic stays alive so a sleeping part can still be woken
  assign CLK_GATES = gates;

  // ---------------------------------------------------------------
  // Async timer oscillator routing
  // ---------------------------------------------------------------
  logic tosc_route;
  assign tosc_route = RC_OSC_IS_SYSCLK & ASYNC_TIMER_CLOCK_SELECT;
  assign TIMER_OSC_ROUTED = tosc_route;
  assign TIMER_OSC_INPUT_ONE = tosc_route & PB_I[XTAL_IN_BIT];
  assign TIMER_OSC_INPUT_TWO = tosc_route & PB_I[XTAL_OUT_BIT];

  // ---------------------------------------------------------------
  // Port pins
  // ---------------------------------------------------------------
  // Directions after the alternate functions have claimed their pins
  logic [PORT_B_W-1:0] b_dir;
  logic [PORT_C_W-1:0] c_dir;
  logic [PORT_D_W-1:0] d_dir;

  // Crystal pins become inputs while they feed the timer oscillator
  always_comb begin
    b_dir = PORT_B_DIR;
    if (tosc_route) begin
      b_dir[XTAL_IN_BIT] = 1'b0;
      b_dir[XTAL_OUT_BIT] = 1'b0;
    end
  end

  // The shared pin is an input while it serves as the reset input
  always_comb begin
    c_dir = PORT_C_DIR;
    if (reset_pin_active) begin
      c_dir[SHARED_RST_BIT] = 1'b0;
    end
  end

  assign d_dir = PORT_D_DIR;

  // ---------------------------------------------------------------
  // Port B
  // ---------------------------------------------------------------
  genvar bi;
  generate
    for (bi = 0; bi < PORT_B_W; bi++) begin : g_pin_b
      assign PB_O[bi] = PORT_B_OUT[bi];
      assign PB_OE_N[bi] = any_rst | ~b_dir[bi];
      assign PB_PU[bi] = ~any_rst & ~b_dir[bi] & PORT_B_PULLUP[bi];
      assign PORT_B_IN[bi] = PB_I[bi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Port C
  // ---------------------------------------------------------------
  // The shared pin reads as zero to the core while it is the reset input
  genvar ci;
  generate
    for (ci = 0; ci < PORT_C_W; ci++) begin : g_pin_c
      assign PC_O[ci] = PORT_C_OUT[ci];
      assign PC_OE_N[ci] = any_rst | ~c_dir[ci];
      assign PC_PU[ci] = ~any_rst & ~c_dir[ci] & PORT_C_PULLUP[ci];
      if (ci == SHARED_RST_BIT) begin : g_shared
        assign PORT_C_IN[ci] = PC_I[ci] & ~reset_pin_active;
      end else begin : g_plain
        assign PORT_C_IN[ci] = PC_I[ci];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Port D
  // ---------------------------------------------------------------
  genvar di;
  generate
    for (di = 0; di < PORT_D_W; di++) begin : g_pin_d
      assign PD_O[di] = PORT_D_OUT[di];
      assign PD_OE_N[di] = any_rst | ~d_dir[di];
      assign PD_PU[di] = ~any_rst & ~d_dir[di] & PORT_D_PULLUP[di];
      assign PORT_D_IN[di] = PD_I[di];
    end
  endgenerate

endmodule

/* File: rtl/sleep_ctl_pkg.sv */
// Constants and types for the sleep mode and reset pin controller.
// Assumes one 20 MHz system clock and a synchronous active-high reset.
// ---------------------------------------------------------------
// Notes on behaviour
// - Idle stops CPU clock; SRAM, timers, serial port, interrupts keep running.
// - Power-down keeps registers, stops oscillator, all but interrupt logic off until wake.
// - Power-save keeps only the asynchronous timer, as time base, and interrupt logic running.
// - ADC noise reduction stops CPU and I/O except async timer and ADC.
// - Standby keeps crystal oscillator and interrupt logic running while everything else sleeps.
// - Any active reset puts all port pins in high impedance, clock or not.
// - Reset pin low beyond minimum pulse length resets; source must hold it.
// - Reset-disable fuse programmed makes shared reset pin an ordinary I/O.
// - RC clock plus async select routes crystal pins to the async timer.
// - Every port bit has its own pull-up, usable while an input.
// - First and third ports are 8 bits wide, second port 7 bits.
// ---------------------------------------------------------------
package sleep_ctl_pkg;

  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RST_MIN_PULSE_NS = 2500;
  localparam int unsigned RST_MIN_CYC =
    (RST_MIN_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned PORT_B_W = 8;
  localparam int unsigned PORT_C_W = 7;
  localparam int unsigned PORT_D_W = 8;
  localparam int unsigned SHARED_RST_BIT = 6;
  localparam int unsigned XTAL_IN_BIT = 6;
  localparam int unsigned XTAL_OUT_BIT = 7;
  localparam int unsigned MODE_W = 3;

  // Clock gate vector bit positions
  localparam int unsigned GT_CPU = 0;
  localparam int unsigned GT_SRAM = 1;
  localparam int unsigned GT_TIMER = 2;
  localparam int unsigned GT_SPI = 3;
  localparam int unsigned GT_IRQ = 4;
  localparam int unsigned GT_ADC = 5;
  localparam int unsigned GT_ASYNC = 6;
  localparam int unsigned GT_OSC = 7;
  localparam int unsigned GT_W = 8;
  localparam logic [7:0] GATES_ALL = 8'hff;

  typedef enum logic [2:0] {
    SM_IDLE = 3'h0,
    SM_ADC_NR = 3'h1,
    SM_PWR_DOWN = 3'h2,
    SM_PWR_SAVE = 3'h3,
    SM_STANDBY = 3'h6
  } sleep_mode_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_RUN = 2'h1,
    ST_SLEEP = 2'h3
  } pm_state_t;

endpackage

/* File: rtl/reset_pin_filter.sv */
// Qualifies the shared reset pin: low for longer than the minimum pulse length gives reset.
// Assumes the pin level is already synchronous to the clock.
`timescale 1ns/100ps
module reset_pin_filter
  import sleep_ctl_pkg::*;
#(
  parameter int unsigned MIN_CYC = RST_MIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pin
  input wire logic enable,
  input wire logic pin_level,
  // Result
  output logic pin_rst
);

  localparam int unsigned CW = $clog2(MIN_CYC + 1);

  // Refuse a filter length that would qualify even a one-cycle low pulse
  if (MIN_CYC < 1) begin : g_bad_min
    $error("MIN_CYC must be at least one");
  end

  logic [CW-1:0] cnt_q, cnt_d;
  logic rst_q, rst_d;

  // Count consecutive low cycles; release as soon as the pin goes high
  always_comb begin
    cnt_d = '0;
    rst_d = 1'b0;
    if (enable && !pin_level) begin
      cnt_d = cnt_q;
      rst_d = rst_q;
      if (cnt_q < CW'(MIN_CYC)) begin
        cnt_d = cnt_q + CW'(1);
      end else begin
        rst_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      rst_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rst_q <= rst_d;
    end
  end

  // Asserts combinationally while qualified so it holds without further edges
  assign pin_rst = rst_q & enable & ~pin_level;

endmodule

/* File: sim/sleep_reset_ctl_assertions.sv */
// Checker for sleep_reset_ctl.
// Sees only the top ports; bound below.
`timescale 1ns/100ps
module sleep_reset_ctl_assertions
  import sleep_ctl_pkg::*;
#(
  parameter int unsigned MIN_RST_CYC = RST_MIN_CYC
) (
  input wire logic CLK, SYS_RST, RESET_PIN_DISABLE_FUSE, WAKE_IRQ, SLEEPING, CHIP_RESET,
  input wire logic TIMER_OSC_ROUTED, TIMER_OSC_INPUT_ONE, TIMER_OSC_INPUT_TWO,
  input wire logic [2:0] SLEEP_MODE,
  input wire logic [7:0] PB_I, PB_OE_N, PD_OE_N, PD_PU, PORT_D_DIR, PORT_D_PULLUP, CLK_GATES,
  input wire logic [6:0] PC_I, PC_OE_N, PORT_C_IN
);
  // ----
  // Edges the reset pin has been low
  // ----
  logic [7:0] low_q, low_d;
  always_comb low_d = (!RESET_PIN_DISABLE_FUSE && !PC_I[6]) ? low_q + 8'h01 : 8'h00;
  always_ff @(posedge CLK) low_q <= SYS_RST ? 8'h00 : low_d;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property gates_p(logic [2:0] m, logic [7:0] g);
    $rose(SLEEPING) && $past(SLEEP_MODE) == m |-> CLK_GATES == g;
  endproperty
  chk_idle_gates: assert property (gates_p(SM_IDLE, 8'hfe))
    else $error("idle gates");
  chk_pdown_gates: assert property (gates_p(SM_PWR_DOWN, 8'h10))
    else $error("power-down gates");
  chk_psave_gates: assert property (gates_p(SM_PWR_SAVE, 8'h50))
    else $error("power-save gates");
  chk_adcnr_gates: assert property (gates_p(SM_ADC_NR, 8'hf0))
    else $error("adc noise gates");
  chk_standby_gates: assert property (gates_p(SM_STANDBY, 8'h90))
    else $error("standby gates");
  chk_reset_tristate: assert property (CHIP_RESET |-> &PB_OE_N && &PC_OE_N && &PD_OE_N)
    else $error("pins driven in reset");
  chk_pin_reset: assert property (low_q > MIN_RST_CYC && !PC_I[6] &&
    !RESET_PIN_DISABLE_FUSE |-> CHIP_RESET) else $error("long low pulse gave no reset");
  chk_fuse_io: assert property (RESET_PIN_DISABLE_FUSE [*3] |->
    !CHIP_RESET && PORT_C_IN[6] == PC_I[6]) else $error("fused pin not plain I/O");
  chk_osc_route: assert property (TIMER_OSC_ROUTED |-> PB_OE_N[7:6] == 2'h3 &&
    TIMER_OSC_INPUT_ONE == PB_I[6] && TIMER_OSC_INPUT_TWO == PB_I[7])
    else $error("timer osc routing");
  chk_port_pullup: assert property (!CHIP_RESET |->
    PD_PU == (PORT_D_PULLUP & ~PORT_D_DIR) && PD_OE_N == ~PORT_D_DIR) else $error("pull-up");
  chk_wake_restore: assert property (SLEEPING && WAKE_IRQ |=>
    !SLEEPING && CLK_GATES == 8'hff) else $error("wake did not restore clocks");
  cover property ($rose(SLEEPING));
  cover property ($rose(CHIP_RESET));
  cover property ($rose(TIMER_OSC_ROUTED));
endmodule
bind sleep_reset_ctl sleep_reset_ctl_assertions #(.MIN_RST_CYC(MIN_RST_CYC)) chk_u (.*);

/* File: sim/pin_partner.sv */
// Far side of one port: outside drive plus a reset source on bit 6.
// Assumes hold() is called just after a rising edge.
`timescale 1ns/100ps
module pin_partner #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] oe_n, o, ext,
  output logic [W-1:0] pin
);
  logic rst_low = 1'b0;
  always_comb
    for (int i = 0; i < W; i++)
      pin[i] = !oe_n[i] ? o[i] : (i == 6 && rst_low) ? 1'b0 : ext[i];
  task automatic hold(input int n, input logic low);
    rst_low = low;
    repeat (n) @(posedge clk);
    #5;
  endtask
endmodule

/* File: sim/sleep_reset_ctl_tb.sv */
// Self-checking bench for sleep_reset_ctl.
// Assumes the bound checker and pin_partner on each port.
`timescale 1ns/100ps
module sleep_reset_ctl_tb
  import sleep_ctl_pkg::*;
;
  logic CLK = 1'b0, SYS_RST = 1'b1, RESET_PIN_DISABLE_FUSE = 1'b0, SLEEP_REQ = 1'b0;
  logic ASYNC_TIMER_CLOCK_SELECT = 1'b0, RC_OSC_IS_SYSCLK = 1'b0, WAKE_IRQ = 1'b0;
  logic [2:0] SLEEP_MODE = 3'h0;
  logic [7:0] PORT_B_OUT = 8'h00, PORT_B_DIR = 8'hff, PORT_B_PULLUP = 8'h00;
  logic [7:0] PORT_D_OUT = 8'h00, PORT_D_DIR = 8'h00, PORT_D_PULLUP = 8'h00;
  logic [6:0] PORT_C_OUT = 7'h00, PORT_C_DIR = 7'h00, PORT_C_PULLUP = 7'h00;
  logic [7:0] b_ext = 8'h5a, d_ext = 8'h3c;
  logic [6:0] c_ext = 7'h7f;
  logic [7:0] PB_I, PB_O, PB_OE_N, PB_PU, PD_I, PD_O, PD_OE_N, PD_PU, PORT_B_IN, PORT_D_IN;
  logic [7:0] CLK_GATES;
  logic [6:0] PC_I, PC_O, PC_OE_N, PC_PU, PORT_C_IN;
  logic TIMER_OSC_INPUT_ONE, TIMER_OSC_INPUT_TWO, TIMER_OSC_ROUTED, CHIP_RESET, SLEEPING;
  int errors = 0, n_compared = 0, cyc = 0;
  sleep_reset_ctl #(.MIN_RST_CYC(3)) dut_u (.*);
  pin_partner #(.W(8)) pb_u (.clk(CLK), .oe_n(PB_OE_N), .o(PB_O), .ext(b_ext), .pin(PB_I));
  pin_partner #(.W(7)) pc_u (.clk(CLK), .oe_n(PC_OE_N), .o(PC_O), .ext(c_ext), .pin(PC_I));
  pin_partner #(.W(8)) pd_u (.clk(CLK), .oe_n(PD_OE_N), .o(PD_O), .ext(d_ext), .pin(PD_I));
  initial forever #25 CLK = ~CLK;
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #5;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset();
    tick(2);
    chk(PB_OE_N, 8'hff);
    chk(CLK_GATES, 8'hff);
    tick(8);
    SYS_RST = 1'b0;
    tick(2);
  endtask
  // Sleep in mode m, stay asleep while the request is still held, then wake
  task automatic sleep_wake(input logic [2:0] m, input logic [7:0] g);
    SLEEP_MODE = m;
    SLEEP_REQ = 1'b1;
    tick(1);
    chk(SLEEPING, 1'b1);
    chk(CLK_GATES, g);
    tick(2);
    SLEEP_REQ = 1'b0;
    chk(CLK_GATES, g);
    WAKE_IRQ = 1'b1;
    tick(1);
    WAKE_IRQ = 1'b0;
    chk(SLEEPING, 1'b0);
    chk(CLK_GATES, 8'hff);
  endtask
  task automatic t_modes();
    sleep_wake(SM_IDLE, 8'hfe);
    sleep_wake(SM_PWR_DOWN, 8'h10);
    sleep_wake(SM_PWR_SAVE, 8'h50);
    sleep_wake(SM_ADC_NR, 8'hf0);
    sleep_wake(SM_STANDBY, 8'h90);
    SLEEP_MODE = 3'h7;
    SLEEP_REQ = 1'b1;
    tick(2);
    SLEEP_REQ = 1'b0;
    chk(SLEEPING, 1'b0);
  endtask
  task automatic t_route();
    ASYNC_TIMER_CLOCK_SELECT = 1'b1;
    RC_OSC_IS_SYSCLK = 1'b1;
    tick(1);
    chk(TIMER_OSC_ROUTED, 1'b1);
    chk(PB_OE_N[7:6], 2'h3);
    chk({TIMER_OSC_INPUT_TWO, TIMER_OSC_INPUT_ONE}, 2'h1);
    RC_OSC_IS_SYSCLK = 1'b0;
    tick(1);
    chk(TIMER_OSC_ROUTED, 1'b0);
    chk(PB_OE_N[7:6], 2'h0);
  endtask
  // Pin reset wakes a power-down sleep; short pulses do not
  task automatic t_pin();
    PORT_C_DIR = 7'h3f;
    PORT_C_PULLUP = 7'h41;
    SLEEP_MODE = SM_PWR_DOWN;
    SLEEP_REQ = 1'b1;
    tick(1);
    SLEEP_REQ = 1'b0;
    chk(SLEEPING, 1'b1);
    pc_u.hold(2, 1'b1);
    chk(CHIP_RESET, 1'b0);
    chk(SLEEPING, 1'b1);
    pc_u.hold(1, 1'b0);
    pc_u.hold(8, 1'b1);
    chk(CHIP_RESET, 1'b1);
    chk(SLEEPING, 1'b0);
    chk(CLK_GATES, 8'hff);
    chk(PC_OE_N, 7'h7f);
    chk(PB_OE_N, 8'hff);
    chk(PC_PU, 7'h00);
    pc_u.hold(1, 1'b0);
    chk(CHIP_RESET, 1'b0);
    RESET_PIN_DISABLE_FUSE = 1'b1;
    PORT_C_DIR = 7'h00;
    pc_u.hold(8, 1'b1);
    chk(CHIP_RESET, 1'b0);
    chk(PORT_C_IN[6], 1'b0);
    chk(PC_PU, 7'h41);
    pc_u.hold(1, 1'b0);
    chk(PORT_C_IN[6], 1'b1);
  endtask
  task automatic t_ports();
    PORT_D_DIR = 8'h0f;
    PORT_D_OUT = 8'ha5;
    PORT_D_PULLUP = 8'h5a;
    PORT_C_DIR = 7'h7f;
    PORT_C_OUT = 7'h55;
    PORT_B_DIR = 8'h0f;
    PORT_B_OUT = 8'hc3;
    PORT_B_PULLUP = 8'hff;
    tick(1);
    chk(PB_OE_N, 8'hf0);
    chk(PB_PU, 8'hf0);
    chk(PORT_B_IN, 8'h53);
    chk(PC_PU, 7'h00);
    chk(PD_OE_N, 8'hf0);
    chk(PD_PU, 8'h50);
    chk(PORT_D_IN, 8'h35);
    chk(PC_OE_N, 7'h00);
    chk(PORT_C_IN, 7'h55);
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    t_reset();
    t_modes();
    t_route();
    t_pin();
    t_ports();
    give_verdict();
  end
endmodule
